// file: dv/wpt_ctrl_asserts.sv
// Purpose: port assertions of the transmitter control block
// Assumes: one clock, synchronous active high reset
// Notes:   bound to every wpt_ctrl instance
module wpt_ctrl_asserts
(
    input logic        clk_sys,
    input logic        rst,
    input logic        psel,
    input logic        penable,
    input logic [7:0]  paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        legAHi,
    input logic        legALo,
    input logic        legBHi,
    input logic        legBLo
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // bus and gate checks
    // ********************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence apbTaken;
        psel && penable && !pready;
    endsequence
    answer_time_a: assert property (apbTaken |=> pready)
        else $error("apb answer late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable, 1))
        else $error("pready without request");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    unmapped_err_a: assert property (pready && paddr > 8'h10 |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && paddr inside {8'h0, 8'h4, 8'h8, 8'hc, 8'h10}
        |-> !pslverr)
        else $error("mapped access refused");
    legs_apart_a: assert property (!(legAHi && legALo) && !(legBHi && legBLo))
        else $error("both switches of one leg on");
    reset_gates_a: assert property ($fell(rst) |-> !(legAHi || legALo || legBHi || legBLo))
        else $error("gates on after reset");
endmodule
bind wpt_ctrl wpt_ctrl_asserts chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .legAHi(legAHi), .legALo(legALo), .legBHi(legBHi),
    .legBLo(legBLo));

// file: dv/wpt_ctrl_tb.sv
// Purpose: self-checking bench of the transmitter control block
// Assumes: short loop period, apb register access
// Notes:   random coil current and packet values, fixed seed
module wpt_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LC = 16;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        sendReq, cepValid, legAHi, legALo, legBHi, legBLo;
    logic [7:0]  paddr, errVal, cepValue;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] coilAmp;
    int          error_cnt, n_checks, amp, ce, tg;
    int          seed = 32'hf022;
    wpt_ctrl #(.LOOP_CYCLES(LC)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cepValid(cepValid),
        .cepValue(cepValue), .coilAmp(coilAmp), .legAHi(legAHi), .legALo(legALo),
        .legBHi(legBHi), .legBLo(legBLo));
    wpt_rx_model rx (.clk_sys(clk_sys), .rst(rst), .sendReq(sendReq), .errVal(errVal),
        .cepValid(cepValid), .cepValue(cepValue));
    // ********************
    // helpers
    // ********************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic cep(input int v);
        @(posedge clk_sys);
        sendReq <= 1'b1;
        errVal  <= v[7:0];
        @(posedge clk_sys);
        sendReq <= 1'b0;
    endtask
    function automatic int tgtOf(input int a, input int c);
        int t;
        t = a + ((a * c) >>> 7);
        return (t < 0) ? 0 : ((t > wpt_pkg::AMP_MAX) ? wpt_pkg::AMP_MAX : t);
    endfunction
    function automatic int freqStep(input int f, input int pid);
        int sv;
        sv = (f < wpt_pkg::BAND1_HZ) ? wpt_pkg::SV_BAND0 :
             (f < wpt_pkg::BAND2_HZ) ? wpt_pkg::SV_BAND1 :
             (f < wpt_pkg::BAND3_HZ) ? wpt_pkg::SV_BAND2 : wpt_pkg::SV_BAND3;
        return f - ((pid * sv) >>> 1);
    endfunction
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ********************
    // clock, watchdog, tests
    // ********************
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        stop_test;
    end
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        sendReq = 1'b0;
        errVal = 8'h0;
        coilAmp = 16'h0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        cep(5);
        rdchk("target", wpt_pkg::REG_TARGET, 32'h0);
        rdchk("ctrl", wpt_pkg::REG_CTRL, 32'h0);
        rdchk("duty", wpt_pkg::REG_DUTY, 32'd5000);
        apb(1'b1, 8'h14, 32'h1);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, wpt_pkg::REG_FREQ, 32'h0);
        rdchk("freq", wpt_pkg::REG_FREQ, 32'd140000);
        apb(1'b1, wpt_pkg::REG_CTRL, 32'h1);
        rdchk("status", wpt_pkg::REG_STATUS, 32'h2);
        rdchk("freq", wpt_pkg::REG_FREQ, 32'd140000);
        rdchk("duty", wpt_pkg::REG_DUTY, 32'd5000);
        amp = 100 + ($random(seed) & 16'h3fff);
        ce = $random(seed) & 8'h3f;
        coilAmp <= amp[15:0];
        cep(ce);
        tg = tgtOf(amp, ce);
        rdchk("target", wpt_pkg::REG_TARGET, tg);
        rdchk("status", wpt_pkg::REG_STATUS, 32'h4);
        chk("legB", 32'h1, {30'h0, legBHi, legBLo});
        coilAmp <= 16'(tg - 20);
        repeat (LC / 2 + 2) @(posedge clk_sys);
        rdchk("freq", wpt_pkg::REG_FREQ, freqStep(140000, wpt_pkg::HB_KP * 20));
        apb(1'b1, wpt_pkg::REG_CTRL, 32'h0);
        rdchk("status", wpt_pkg::REG_STATUS, 32'h1);
        chk("gates", 32'h0, {28'h0, legAHi, legALo, legBHi, legBLo});
        apb(1'b1, wpt_pkg::REG_CTRL, 32'h3);
        cep(0);
        rdchk("status", wpt_pkg::REG_STATUS, 32'h1c);
        rdchk("freq", wpt_pkg::REG_FREQ, 32'd145000);
        rdchk("duty", wpt_pkg::REG_DUTY, 32'd2000);
        coilAmp <= 16'(tg - 40);
        repeat (LC / 2 + 2) @(posedge clk_sys);
        rdchk("duty", wpt_pkg::REG_DUTY, 2000 + wpt_pkg::FB_KP * 20);
        rdchk("freq", wpt_pkg::REG_FREQ, 32'd145000);
        coilAmp <= 16'd4000;
        cep(127);
        @(posedge clk_sys);
        coilAmp <= 16'h0;
        rdchk("target", wpt_pkg::REG_TARGET, tgtOf(4000, 127));
        repeat (4 * LC) @(posedge clk_sys);
        rdchk("status", wpt_pkg::REG_STATUS, 32'h0c);
        rdchk("duty", wpt_pkg::REG_DUTY, 32'd5000);
        rdchk("freq", wpt_pkg::REG_FREQ, 32'd110000);
        stop_test;
    end
endmodule

// file: dv/wpt_rx_model.sv
// Purpose: power receiver model sending control error packets
// Assumes: one packet per send request
// Notes:   value line toggles while no packet is carried
module wpt_rx_model
#(
    parameter logic RES_SENSE_ABSENT = 1'b0
)
(
    input  logic       clk_sys,
    input  logic       rst,
    input  logic       sendReq,
    input  logic [7:0] errVal,
    output logic       cepValid,
    output logic [7:0] cepValue
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_sys)
    begin
        cepValid <= sendReq && !rst && !RES_SENSE_ABSENT;
        cepValue <= rst ? 8'h5a : (sendReq ? errVal : ~cepValue);
    end
endmodule

// file: hdl/wpt_ctrl.sv
// Purpose: power control loop of an inductive transmitter with apb registers
// Assumes: packet decoder and current sense deliver synchronous inputs
// Notes:   loop runs once per loop period while power is transferred
//
// Local design decisions: the APB register port and the address map.

module wpt_ctrl
#(
    parameter int LOOP_CYCLES = wpt_pkg::LOOP_CYCLES
)
(
    input  logic        clk_sys,
    input  logic        rst,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        cepValid,
    input  logic [7:0]  cepValue,
    input  logic [15:0] coilAmp,
    output logic        legAHi,
    output logic        legALo,
    output logic        legBHi,
    output logic        legBLo
);

    localparam int CNT_W = $clog2(LOOP_CYCLES);

    logic                   pready_ff;
    logic                   pslverr_ff;
    logic [31:0]            prdata_ff;
    logic [1:0]             ctrl_ff;
    logic                   nxt_pready;
    logic                   nxt_pslverr;
    logic [31:0]            nxt_prdata;
    logic [1:0]             nxt_ctrl;
    logic                   accWrite;
    logic                   hit;
    logic [31:0]            rdMux;

    logic [CNT_W-1:0]       cnt_ff;
    logic                   tick_ff;
    logic [CNT_W-1:0]       nxt_cnt;
    logic                   nxt_tick;

    wpt_pkg::wpt_state_type state_ff;
    wpt_pkg::wpt_state_type nxt_state;
    logic                   topoFull_ff;
    logic                   dutyMode_ff;
    logic [17:0]            freq_ff;
    logic [12:0]            duty_ff;
    logic [15:0]            target_ff;
    logic signed [31:0]     integ_ff;
    logic signed [31:0]     errPrev_ff;
    logic [31:0]            phaseInc_ff;
    logic                   nxt_topoFull;
    logic                   nxt_dutyMode;
    logic [17:0]            nxt_freq;
    logic [12:0]            nxt_duty;
    logic [15:0]            nxt_target;
    logic signed [31:0]     nxt_integ;
    logic signed [31:0]     nxt_errPrev;
    logic [31:0]            nxt_phaseInc;

    logic signed [31:0]     kp;
    logic signed [31:0]     ki;
    logic signed [31:0]     kd;
    logic signed [31:0]     miLim;
    logic signed [31:0]     pidLim;
    logic signed [31:0]     svHalf;
    logic signed [31:0]     err;
    logic signed [31:0]     integSum;
    logic signed [31:0]     integNew;
    logic signed [31:0]     pidRaw;
    logic signed [31:0]     pidOut;
    logic signed [31:0]     step;
    logic signed [31:0]     freqCalc;
    logic signed [31:0]     dutyCalc;
    logic signed [31:0]     ceProd;
    logic signed [31:0]     tgtCalc;
    logic [39:0]            incProd;

    // ************************************************************
    // apb slave, answers one cycle into the access phase
    // ************************************************************
    assign accWrite = psel && penable && pready_ff && pwrite;

    always_comb
    begin
        hit = 1'b1;
        case (paddr)
            wpt_pkg::REG_CTRL:   rdMux = {30'h0, ctrl_ff};
            wpt_pkg::REG_STATUS: rdMux = {27'h0, dutyMode_ff, topoFull_ff, state_ff};
            wpt_pkg::REG_FREQ:   rdMux = {14'h0, freq_ff};
            wpt_pkg::REG_DUTY:   rdMux = {19'h0, duty_ff};
            wpt_pkg::REG_TARGET: rdMux = {16'h0, target_ff};
            default:
            begin
                rdMux = 32'h0;
                hit   = 1'b0;
            end
        endcase
        nxt_pready  = psel && penable && !pready_ff;
        nxt_pslverr = nxt_pready && !hit;
        nxt_prdata  = (nxt_pready && !pwrite) ? rdMux : 32'h0;
        nxt_ctrl    = ctrl_ff;
        if (accWrite && paddr == wpt_pkg::REG_CTRL)
            nxt_ctrl = pwdata[1:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
            ctrl_ff    <= wpt_pkg::CTRL_RST;
        end
        else
        begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
            ctrl_ff    <= nxt_ctrl;
        end
    end

    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // ************************************************************
    // loop period tick
    // ************************************************************
    always_comb
    begin
        nxt_cnt  = cnt_ff + 1'b1;
        nxt_tick = 1'b0;
        if (state_ff != wpt_pkg::ST_RUN)
            nxt_cnt = '0;
        else if (cnt_ff == CNT_W'(LOOP_CYCLES - 1))
        begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    // ************************************************************
    // loop constants and pid arithmetic
    // ************************************************************
    always_comb
    begin
        if (topoFull_ff)
        begin
            kp     = 32'(wpt_pkg::FB_KP);
            ki     = 32'(wpt_pkg::FB_KI);
            kd     = 32'(wpt_pkg::FB_KD);
            miLim  = 32'(wpt_pkg::FB_MI * wpt_pkg::KI_SCALE);
            pidLim = 32'(wpt_pkg::FB_MPID);
        end
        else
        begin
            kp     = 32'(wpt_pkg::HB_KP);
            ki     = 32'(wpt_pkg::HB_KI);
            kd     = 32'(wpt_pkg::HB_KD);
            miLim  = 32'(wpt_pkg::HB_MI * wpt_pkg::KI_SCALE);
            pidLim = 32'(wpt_pkg::HB_MPID);
        end
        if (freq_ff < 18'(wpt_pkg::BAND1_HZ))
            svHalf = 32'(wpt_pkg::SV_BAND0);
        else if (freq_ff < 18'(wpt_pkg::BAND2_HZ))
            svHalf = 32'(wpt_pkg::SV_BAND1);
        else if (freq_ff < 18'(wpt_pkg::BAND3_HZ))
            svHalf = 32'(wpt_pkg::SV_BAND2);
        else
            svHalf = 32'(wpt_pkg::SV_BAND3);
        // 1 mA per count of the current sense
        err      = $signed({16'h0, target_ff}) - $signed({16'h0, coilAmp});
        integSum = integ_ff + ki * err;
        if (integSum > miLim)
            integNew = miLim;
        else if (integSum < -miLim)
            integNew = -miLim;
        else
            integNew = integSum;
        pidRaw = kp * err + integNew / 32'(wpt_pkg::KI_SCALE)
               + kd * (err - errPrev_ff);
        if (pidRaw > pidLim)
            pidOut = pidLim;
        else if (pidRaw < -pidLim)
            pidOut = -pidLim;
        else
            pidOut = pidRaw;
        // positive output asks for more power
        step     = (pidOut * svHalf) >>> 1;
        freqCalc = $signed({14'h0, freq_ff}) - step;
        dutyCalc = $signed({19'h0, duty_ff}) - 32'(wpt_pkg::DUTY_SV) * pidOut;
        ceProd   = ($signed({16'h0, coilAmp}) * 32'($signed(cepValue)))
                 >>> wpt_pkg::CE_SHIFT;
        tgtCalc  = $signed({16'h0, coilAmp}) + ceProd;
        incProd  = {22'h0, freq_ff} * {18'h0, wpt_pkg::PHASE_MUL};
    end

    // ************************************************************
    // topology, mode and operating point
    // ************************************************************
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_topoFull = topoFull_ff;
        nxt_dutyMode = dutyMode_ff;
        nxt_freq     = freq_ff;
        nxt_duty     = duty_ff;
        nxt_target   = target_ff;
        nxt_integ    = integ_ff;
        nxt_errPrev  = errPrev_ff;
        nxt_phaseInc = 32'(incProd >> wpt_pkg::PHASE_SHIFT);
        if (cepValid && state_ff != wpt_pkg::ST_OFF)
        begin
            if (tgtCalc < 0)
                nxt_target = 16'h0;
            else if (tgtCalc > 32'(wpt_pkg::AMP_MAX))
                nxt_target = 16'(wpt_pkg::AMP_MAX);
            else
                nxt_target = tgtCalc[15:0];
        end
        case (state_ff)
            wpt_pkg::ST_OFF:
            begin
                if (ctrl_ff[wpt_pkg::CTRL_EN_BIT])
                begin
                    nxt_state    = wpt_pkg::ST_PING;
                    nxt_topoFull = 1'b0;
                    nxt_dutyMode = 1'b0;
                    nxt_freq     = 18'(wpt_pkg::FREQ_PING_HZ);
                    nxt_duty     = 13'(wpt_pkg::DUTY_MAX);
                    nxt_integ    = '0;
                    nxt_errPrev  = '0;
                end
            end
            wpt_pkg::ST_PING:
            begin
                if (!ctrl_ff[wpt_pkg::CTRL_EN_BIT])
                    nxt_state = wpt_pkg::ST_OFF;
                else if (cepValid)
                begin
                    nxt_state = wpt_pkg::ST_RUN;
                    if (ctrl_ff[wpt_pkg::CTRL_HIPWR_BIT])
                    begin
                        nxt_topoFull = 1'b1;
                        nxt_dutyMode = 1'b1;
                        nxt_freq     = 18'(wpt_pkg::FREQ_FULL_HZ);
                        nxt_duty     = 13'(wpt_pkg::DUTY_FULL_START);
                        nxt_integ    = '0;
                        nxt_errPrev  = '0;
                    end
                end
            end
            wpt_pkg::ST_RUN:
            begin
                if (!ctrl_ff[wpt_pkg::CTRL_EN_BIT])
                    nxt_state = wpt_pkg::ST_OFF;
                else if (tick_ff)
                begin
                    nxt_integ   = integNew;
                    nxt_errPrev = err;
                    if (!dutyMode_ff)
                    begin
                        nxt_duty = 13'(wpt_pkg::DUTY_MAX);
                        if (freqCalc >= 32'(wpt_pkg::FREQ_MAX_HZ))
                        begin
                            nxt_freq = 18'(wpt_pkg::FREQ_MAX_HZ);
                            if (pidOut < 0)
                                nxt_dutyMode = 1'b1;
                        end
                        else if (freqCalc <= 32'(wpt_pkg::FREQ_MIN_HZ))
                            nxt_freq = 18'(wpt_pkg::FREQ_MIN_HZ);
                        else
                            nxt_freq = freqCalc[17:0];
                    end
                    else
                    begin
                        nxt_freq = 18'(wpt_pkg::FREQ_MAX_HZ);
                        if (dutyCalc >= 32'(wpt_pkg::DUTY_MAX))
                        begin
                            nxt_duty = 13'(wpt_pkg::DUTY_MAX);
                            if (pidOut > 0)
                            begin
                                nxt_dutyMode = 1'b0;
                                nxt_integ    = '0;
                            end
                        end
                        else if (dutyCalc <= 32'(wpt_pkg::DUTY_ABS_MIN))
                            nxt_duty = 13'(wpt_pkg::DUTY_ABS_MIN);
                        else
                            nxt_duty = dutyCalc[12:0];
                    end
                end
            end
            default:
            begin
                nxt_state = wpt_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff    <= wpt_pkg::ST_OFF;
            topoFull_ff <= 1'b0;
            dutyMode_ff <= 1'b0;
            freq_ff     <= 18'(wpt_pkg::FREQ_PING_HZ);
            duty_ff     <= 13'(wpt_pkg::DUTY_MAX);
            target_ff   <= 16'h0;
            integ_ff    <= '0;
            errPrev_ff  <= '0;
            phaseInc_ff <= 32'h0;
        end
        else
        begin
            state_ff    <= nxt_state;
            topoFull_ff <= nxt_topoFull;
            dutyMode_ff <= nxt_dutyMode;
            freq_ff     <= nxt_freq;
            duty_ff     <= nxt_duty;
            target_ff   <= nxt_target;
            integ_ff    <= nxt_integ;
            errPrev_ff  <= nxt_errPrev;
            phaseInc_ff <= nxt_phaseInc;
        end
    end

    // ************************************************************
    // inverter gate drive
    // ************************************************************
    wpt_gate_pwm u_pwm
    (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .drvEn      (state_ff != wpt_pkg::ST_OFF),
        .fullBridge (topoFull_ff),
        .phaseInc   (phaseInc_ff),
        .duty       (duty_ff),
        .legAHi     (legAHi),
        .legALo     (legALo),
        .legBHi     (legBHi),
        .legBLo     (legBLo)
    );

endmodule

// file: hdl/wpt_gate_pwm.sv
// Purpose: gate drive generator for half-bridge and full-bridge inverter
// Assumes: phase increment per clock and duty in 0.01 % units
// Notes:   half-bridge holds leg b low side on; outputs are registered

module wpt_gate_pwm
(
    input  logic        clk_sys,
    input  logic        rst,
    input  logic        drvEn,
    input  logic        fullBridge,
    input  logic [31:0] phaseInc,
    input  logic [12:0] duty,
    output logic        legAHi,
    output logic        legALo,
    output logic        legBHi,
    output logic        legBLo
);

    logic [31:0] phase_ff;
    logic [31:0] nxt_phase;
    logic [3:0]  gate_ff;
    logic [3:0]  nxt_gate;
    logic [31:0] posA;
    logic [31:0] posB;
    logic [31:0] limit;
    logic        pulseA;
    logic        pulseB;

    // ************************************************************
    // phase accumulation and pulse compare
    // ************************************************************
    always_comb
    begin
        nxt_phase = drvEn ? phase_ff + phaseInc : 32'h0;
        posA      = {16'h0, phase_ff[31:16]} * 32'(wpt_pkg::DUTY_FULL_SCALE);
        posB      = {16'h0, 1'b0, phase_ff[30:16]} * 32'(wpt_pkg::DUTY_FULL_SCALE);
        limit     = {3'h0, duty, 16'h0};
        pulseA    = !phase_ff[31] && (posA < limit);
        pulseB    = phase_ff[31] && (posB < limit);
        nxt_gate  = 4'h0;
        if (drvEn && fullBridge)
            nxt_gate = {pulseB, pulseA, pulseA, pulseB};
        else if (drvEn)
            nxt_gate = {1'b0, 1'b1, pulseA, pulseB};
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            phase_ff <= 32'h0;
            gate_ff  <= 4'h0;
        end
        else
        begin
            phase_ff <= nxt_phase;
            gate_ff  <= nxt_gate;
        end
    end

    assign legALo = gate_ff[0];
    assign legAHi = gate_ff[1];
    assign legBLo = gate_ff[2];
    assign legBHi = gate_ff[3];

endmodule

// file: hdl/wpt_pkg.sv
// Purpose: shared constants of the inductive power transmitter control block
// Assumes: 100 MHz system clock, frequency in Hz, duty cycle in 0.01 % steps
// Notes:   current and targets in mA, loop gains in integer or 1/100 units

package wpt_pkg;

    // ************************************************************
    // clock and loop timing
    // ************************************************************
    localparam int CLK_HZ        = 100_000_000;
    localparam int LOOP_TIME_US  = 1000;
    localparam int LOOP_CYCLES   = (CLK_HZ / 1_000_000) * LOOP_TIME_US;

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FREQ   = 8'h08;
    localparam logic [7:0] REG_DUTY   = 8'h0c;
    localparam logic [7:0] REG_TARGET = 8'h10;
    localparam int         CTRL_EN_BIT    = 0;
    localparam int         CTRL_HIPWR_BIT = 1;
    localparam logic [1:0] CTRL_RST       = 2'h0;
    localparam int         STAT_TOPO_BIT  = 3;
    localparam int         STAT_MODE_BIT  = 4;

    // ************************************************************
    // frequency window, start points and scaling bands
    // ************************************************************
    localparam int FREQ_MIN_HZ  = 110_000;
    localparam int FREQ_MAX_HZ  = 145_000;
    localparam int FREQ_PING_HZ = 140_000;
    localparam int FREQ_FULL_HZ = 145_000;
    localparam int BAND1_HZ     = 115_000;
    localparam int BAND2_HZ     = 120_000;
    localparam int BAND3_HZ     = 135_000;
    localparam int SV_BAND0     = 3;
    localparam int SV_BAND1     = 4;
    localparam int SV_BAND2     = 6;
    localparam int SV_BAND3     = 10;

    // ************************************************************
    // duty cycle limits, 0.01 % per unit
    // ************************************************************
    localparam int DUTY_MAX        = 5000;
    localparam int DUTY_FREQ_MIN   = 4000;
    localparam int DUTY_ABS_MIN    = 500;
    localparam int DUTY_FULL_START = 2000;
    localparam int DUTY_SV         = -1;
    localparam int DUTY_FULL_SCALE = 10000;

    // ************************************************************
    // loop constants per topology, integral gain in 1/100
    // ************************************************************
    localparam int KI_SCALE = 100;
    localparam int FB_KP    = 2;
    localparam int FB_KI    = 1;
    localparam int FB_KD    = 0;
    localparam int FB_MI    = 500;
    localparam int FB_MPID  = 5000;
    localparam int HB_KP    = 5;
    localparam int HB_KI    = 2;
    localparam int HB_KD    = 0;
    localparam int HB_MI    = 1000;
    localparam int HB_MPID  = 10000;

    // ************************************************************
    // packet scaling and phase accumulator
    // ************************************************************
    localparam int          CE_SHIFT    = 7;
    localparam int          AMP_MAX     = 65535;
    localparam logic [21:0] PHASE_MUL   = 22'd2814750;
    localparam int          PHASE_SHIFT = 16;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_PING = 3'b010,
        ST_RUN  = 3'b100
    } wpt_state_type;

endpackage
